// ===== oep_pkg.sv
/*
 Constants for the one-time programmable memory controller: pin timing,
 programming pulse counts and sequence states.
 Assumes a 40 MHz system clock; supply switching is done by board logic.
*/
package oep_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Read timing, ns
  localparam int ADDRESS_ACCESS_DELAY_NS = 90;
  localparam int CE_ACCESS_DELAY_NS = 90;
  localparam int OE_ACCESS_DELAY_NS = 50;
  localparam int OUTPUT_FLOAT_DELAY_NS = 40;
  // Programming timing, us
  localparam int PROGRAM_PULSE_WIDTH_MIN_US = 95;
  localparam int PROGRAM_PULSE_WIDTH_NOM_US = 100;
  localparam int PROGRAM_PULSE_WIDTH_MAX_US = 105;
  localparam int PROG_SETUP_US = 2;
  localparam int PROG_VERIFY_DV_US = 1;
  // Least times round up
  localparam int ACC_CYC = (ADDRESS_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYC = (PROGRAM_PULSE_WIDTH_NOM_US * 1000000) / CLK_PERIOD_PS;
  localparam int PULSE_MIN_CYC = (PROGRAM_PULSE_WIDTH_MIN_US * 1000000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int PULSE_MAX_CYC = (PROGRAM_PULSE_WIDTH_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (PROG_SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DV_CYC = (PROG_VERIFY_DV_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MAX_RETRY = 10;
  localparam int RETRY_W = 4;
  localparam int TMR_W = 18;
  // Identification address: line nine high level, line zero selects byte
  localparam int ID_MODE_BIT = 9;
  localparam int ID_SELECT_BIT = 0;

  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_READ   = 11'h002,
    ST_FLOAT  = 11'h004,
    ST_PWRUP  = 11'h008,
    ST_PULSE  = 11'h010,
    ST_GAP    = 11'h020,
    ST_VFY    = 11'h040,
    ST_REPULSE= 11'h080,
    ST_PWRDN  = 11'h100,
    ST_FINAL  = 11'h200,
    ST_DONE   = 11'h400
  } oep_state_t;
endpackage : oep_pkg

// ===== oep_sync.sv
/*
 Three-stage input synchroniser for the memory data pins.
 Assumes the pins change asynchronously to sys_clk.
*/
`timescale 1ns/1ps
module oep_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [W-1:0] din, // Asynchronous input
  output logic [W-1:0] dout // Settled value
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit counts only once the second and third stages agree
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : oep_sync

// ===== oep_ctrl.sv
/*
 Host controller for a 64K x 8 one-time programmable memory: single reads,
 identification reads and the pulse-count programming sequence.
 Assumes board switches drive the supply and program-supply levels from
 vcc_prog_en / vpp_en / id_hv_en, and that a byte source answers src_addr
 with src_data in the next cycle.
*/
`timescale 1ns/1ps

module oep_ctrl #(
  parameter int PULSE_CYCLES = oep_pkg::PULSE_CYC, // Program pulse length
  parameter int SETUP_CYCLES = oep_pkg::SETUP_CYC, // Supply and setup wait
  parameter int LAST_ADDR = 16'hFFFF // Last address programmed
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic rd_req, // Read request pulse
  input wire logic rd_id, // Read is an identification read
  input wire logic [15:0] rd_addr, // Read address
  output logic rd_ready, // Ready for a request
  output logic rd_valid, // Read data valid pulse
  output logic [7:0] rd_data, // Read data
  input wire logic prog_start, // Start programming pulse
  output logic [15:0] src_addr, // Source data address
  input wire logic [7:0] src_data, // Source byte for src_addr
  output logic prog_busy, // Programming in progress
  output logic prog_done, // Programming finished pulse
  output logic prog_pass, // Last run passed
  output logic prog_fail, // Last run failed
  output logic [15:0] fail_addr, // Failing address
  output logic [3:0] fail_retries, // Extra pulses at failure
  output logic [15:0] mem_addr, // Memory address pins
  output logic mem_ce_n, // Chip select, active low
  output logic mem_oe_n, // Output gate, active low
  output logic vpp_en, // Raise output gate pin to program level
  output logic vcc_prog_en, // Raise supply to program level
  output logic id_hv_en, // Raise address nine to identification level
  input wire logic [7:0] mem_dq_in, // Data pins in
  output logic [7:0] mem_dq_out, // Data pins out
  output logic mem_dq_oe // Data pins driven
);
  oep_pkg::oep_state_t st_r;
  logic [oep_pkg::TMR_W-1:0] tmr_r;
  logic [oep_pkg::RETRY_W-1:0] retry_r;
  logic pass2_r;
  logic [7:0] dq_s;
  logic tmr_zero;
  logic at_last;
  localparam logic [oep_pkg::TMR_W-1:0] T_ACC = oep_pkg::TMR_W'(oep_pkg::ACC_CYC + 3);
  localparam logic [oep_pkg::TMR_W-1:0] T_FLT = oep_pkg::TMR_W'(oep_pkg::FLOAT_CYC);
  localparam logic [oep_pkg::TMR_W-1:0] T_PW = oep_pkg::TMR_W'(PULSE_CYCLES);
  // Pulse states run two cycles longer so data leads and trails the strobe
  localparam logic [oep_pkg::TMR_W-1:0] T_PW2 = oep_pkg::TMR_W'(PULSE_CYCLES + 2);
  localparam logic [oep_pkg::TMR_W-1:0] T_SU = oep_pkg::TMR_W'(SETUP_CYCLES);
  localparam logic [oep_pkg::TMR_W-1:0] T_VF = oep_pkg::TMR_W'(oep_pkg::DV_CYC + 3);
  localparam logic [15:0] A_LAST = 16'(LAST_ADDR);

  oep_sync #(.W(8)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(mem_dq_in),
    .dout(dq_s)
  );

  assign tmr_zero = (tmr_r == '0);
  assign at_last = (mem_addr == A_LAST);
  assign rd_ready = (st_r == oep_pkg::ST_IDLE);
  assign prog_busy = !(st_r inside {oep_pkg::ST_IDLE, oep_pkg::ST_READ, oep_pkg::ST_FLOAT});
  assign src_addr = mem_addr;

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= oep_pkg::ST_IDLE;
      tmr_r <= '0;
      pass2_r <= 1'b0;
    end else begin
      if (!tmr_zero) begin
        tmr_r <= tmr_r - 1'b1;
      end
      unique case (st_r)
        oep_pkg::ST_IDLE: begin
          if (prog_start) begin
            st_r <= oep_pkg::ST_PWRUP;
            tmr_r <= T_SU;
            pass2_r <= 1'b0;
          end else if (rd_req) begin
            st_r <= oep_pkg::ST_READ;
            tmr_r <= T_ACC;
          end
        end
        oep_pkg::ST_READ: begin
          if (tmr_zero) begin
            st_r <= oep_pkg::ST_FLOAT;
            tmr_r <= T_FLT;
          end
        end
        oep_pkg::ST_FLOAT: begin
          if (tmr_zero) begin
            st_r <= oep_pkg::ST_IDLE;
          end
        end
        oep_pkg::ST_PWRUP: begin
          if (tmr_zero) begin
            st_r <= oep_pkg::ST_PULSE;
            tmr_r <= T_PW2;
          end
        end
        oep_pkg::ST_PULSE, oep_pkg::ST_REPULSE: begin
          if (tmr_zero) begin
            st_r <= oep_pkg::ST_GAP;
            tmr_r <= T_SU;
          end
        end
        oep_pkg::ST_GAP: begin
          if (tmr_zero) begin
            if (!pass2_r && !at_last) begin
              st_r <= oep_pkg::ST_PULSE;
              tmr_r <= T_PW2;
            end else if (!pass2_r) begin
              pass2_r <= 1'b1;
              st_r <= oep_pkg::ST_VFY;
              tmr_r <= T_VF;
            end else begin
              st_r <= oep_pkg::ST_VFY;
              tmr_r <= T_VF;
            end
          end
        end
        oep_pkg::ST_VFY: begin
          if (tmr_zero) begin
            if (dq_s != src_data) begin
              if (retry_r == oep_pkg::RETRY_W'(oep_pkg::MAX_RETRY)) begin
                st_r <= oep_pkg::ST_DONE;
              end else begin
                st_r <= oep_pkg::ST_REPULSE;
                tmr_r <= T_PW2;
              end
            end else if (at_last) begin
              st_r <= oep_pkg::ST_PWRDN;
              tmr_r <= T_SU;
            end else begin
              tmr_r <= T_VF;
            end
          end
        end
        oep_pkg::ST_PWRDN: begin
          if (tmr_zero) begin
            st_r <= oep_pkg::ST_FINAL;
            tmr_r <= T_ACC;
          end
        end
        oep_pkg::ST_FINAL: begin
          if (tmr_zero) begin
            if (dq_s != src_data || at_last) begin
              st_r <= oep_pkg::ST_DONE;
            end else begin
              tmr_r <= T_ACC;
            end
          end
        end
        oep_pkg::ST_DONE: begin
          st_r <= oep_pkg::ST_IDLE;
        end
        default: begin
          st_r <= oep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address: first-pass and verify walks restart at zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_addr <= '0;
    end else if (st_r == oep_pkg::ST_IDLE && prog_start) begin
      mem_addr <= '0;
    end else if (st_r == oep_pkg::ST_IDLE && rd_req) begin
      if (rd_id) begin
        mem_addr <= {15'h0000, rd_addr[oep_pkg::ID_SELECT_BIT]};
      end else begin
        mem_addr <= rd_addr;
      end
    end else if (tmr_zero && st_r == oep_pkg::ST_GAP && !pass2_r) begin
      mem_addr <= at_last ? 16'h0000 : mem_addr + 16'h0001;
    end else if (tmr_zero && st_r == oep_pkg::ST_VFY && dq_s == src_data) begin
      mem_addr <= at_last ? 16'h0000 : mem_addr + 16'h0001;
    end else if (tmr_zero && st_r == oep_pkg::ST_FINAL && dq_s == src_data && !at_last) begin
      mem_addr <= mem_addr + 16'h0001;
    end
  end

  // Extra pulse count per address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      retry_r <= '0;
    end else if (st_r == oep_pkg::ST_IDLE || (tmr_zero && st_r == oep_pkg::ST_VFY
                 && dq_s == src_data)) begin
      retry_r <= '0;
    end else if (st_r == oep_pkg::ST_REPULSE && tmr_r == T_PW) begin
      retry_r <= retry_r + 1'b1;
    end
  end

  // Pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      vpp_en <= 1'b0;
      vcc_prog_en <= 1'b0;
      id_hv_en <= 1'b0;
      mem_dq_out <= '0;
      mem_dq_oe <= 1'b0;
    end else begin
      // Reads: both selects low only during access; data pins stay released
      // Verify raises the strobe on its last cycle so a following pulse is a clean edge
      mem_ce_n <= !((st_r == oep_pkg::ST_IDLE && rd_req && !prog_start)
                   || (st_r == oep_pkg::ST_READ && !tmr_zero)
                   || (st_r == oep_pkg::ST_VFY && !tmr_zero)
                   || st_r == oep_pkg::ST_FINAL
                   || (st_r == oep_pkg::ST_PWRDN && tmr_zero)
                   || ((st_r == oep_pkg::ST_PULSE || st_r == oep_pkg::ST_REPULSE)
                       && !tmr_zero && tmr_r <= T_PW));
      mem_oe_n <= !((st_r == oep_pkg::ST_IDLE && rd_req && !prog_start)
                   || (st_r == oep_pkg::ST_READ && !tmr_zero)
                   || (st_r == oep_pkg::ST_PWRDN && tmr_zero)
                   || st_r == oep_pkg::ST_FINAL);
      if (st_r == oep_pkg::ST_IDLE && rd_req && !prog_start) begin
        id_hv_en <= rd_id;
      end else if (st_r == oep_pkg::ST_FLOAT && tmr_zero) begin
        id_hv_en <= 1'b0;
      end
      // Program-supply only raised during programming, never with the output gate
      vpp_en <= st_r inside {oep_pkg::ST_PWRUP, oep_pkg::ST_PULSE, oep_pkg::ST_GAP,
                             oep_pkg::ST_VFY, oep_pkg::ST_REPULSE};
      vcc_prog_en <= vpp_en || (st_r == oep_pkg::ST_IDLE && prog_start);
      mem_dq_out <= src_data;
      // First pulse cycle stays released: the memory may still float from a verify
      mem_dq_oe <= st_r inside {oep_pkg::ST_PULSE, oep_pkg::ST_REPULSE}
                   && tmr_r != T_PW2;
    end
  end

  // Results
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      prog_done <= 1'b0;
      prog_pass <= 1'b0;
      prog_fail <= 1'b0;
      fail_addr <= '0;
      fail_retries <= '0;
    end else begin
      rd_valid <= (st_r == oep_pkg::ST_READ && tmr_zero);
      if (st_r == oep_pkg::ST_READ && tmr_zero) begin
        rd_data <= dq_s;
      end
      prog_done <= (st_r == oep_pkg::ST_DONE);
      if (st_r == oep_pkg::ST_DONE) begin
        prog_pass <= !prog_fail;
      end
      if (st_r == oep_pkg::ST_IDLE && prog_start) begin
        prog_fail <= 1'b0;
        prog_pass <= 1'b0;
      end else if (tmr_zero && ((st_r == oep_pkg::ST_VFY
                   && retry_r == oep_pkg::RETRY_W'(oep_pkg::MAX_RETRY))
                   || st_r == oep_pkg::ST_FINAL) && dq_s != src_data) begin
        prog_fail <= 1'b1;
        fail_addr <= mem_addr;
        fail_retries <= retry_r;
      end
    end
  end

  a_pulse_len: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(mem_ce_n) && vpp_en |-> !mem_ce_n [*8]) else $error("Pulse too short");
  a_retry_cap: assert property (@(posedge sys_clk) disable iff (reset)
    retry_r <= oep_pkg::RETRY_W'(oep_pkg::MAX_RETRY)) else $error("Retry over limit");
  a_no_fight: assert property (@(posedge sys_clk) disable iff (reset)
    !(mem_dq_oe && !mem_oe_n)) else $error("Data pin contention");
  a_vpp_oe: assert property (@(posedge sys_clk) disable iff (reset)
    vpp_en |-> mem_oe_n) else $error("Output gate low at program level");
  a_id_addr: assert property (@(posedge sys_clk) disable iff (reset)
    id_hv_en && !mem_ce_n |-> mem_addr[15:1] == 15'h0000) else $error("Id address");
  a_read_wait: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(rd_valid) |-> $past(!mem_oe_n, 2)) else $error("Read too early");
  a_fail_stop: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(prog_fail) |-> ##[1:3] st_r == oep_pkg::ST_IDLE) else $error("No stop");
  a_retry_clr: assert property (@(posedge sys_clk) disable iff (reset)
    st_r == oep_pkg::ST_VFY && $changed(mem_addr) |-> retry_r == '0)
    else $error("Retry kept");

  // Strobe low time, for the exact pulse width check
  logic [oep_pkg::TMR_W-1:0] low_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (reset || mem_ce_n) begin
      low_cnt_r <= '0;
    end else begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  a_pulse_exact: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(mem_ce_n) && mem_dq_oe |-> low_cnt_r == T_PW) else $error("Pulse width");
endmodule : oep_ctrl

// ===== oep_mem_model.sv
/*
 Behavioural model of the 64K x 8 one-time programmable memory.
 Assumes the controller pins of oep_ctrl; it resolves the data wire itself.
*/
`timescale 1ns/1ps
module oep_mem_model #(
  parameter logic [7:0] MAKER_ID = 8'h5C, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h63, // Arbitrary value
  parameter logic [15:0] SLOW_ADDR = 16'h0002, // Byte that needs three pulses
  parameter realtime PW_MIN_NS = 237.5, // Shortest legal pulse, scaled
  parameter realtime PW_MAX_NS = 262.5 // Longest legal pulse, scaled
) (
  input wire logic [15:0] mem_addr, // Address pins
  input wire logic mem_ce_n, // Chip select, active low
  input wire logic mem_oe_n, // Output gate, active low
  input wire logic vpp_en, // Program level on output gate pin
  input wire logic vcc_prog_en, // Program supply level
  input wire logic id_hv_en, // Identification level on line nine
  input wire logic [7:0] mem_dq_out, // Controller data
  input wire logic mem_dq_oe, // Controller drives data
  output logic [7:0] mem_dq_in, // Resolved data wire
  output int pulses, // Program pulses seen
  output int faults // Contention or pulse width errors
);
  logic [7:0] mem [0:65535];
  int hits [0:15];
  logic [7:0] val = 8'h00;
  logic [7:0] last = 8'h00;
  logic drv = 1'b0;
  realtime t_low = 0.0;
  // Verify reads at program supply are driven with the output gate high
  wire en = !mem_ce_n && (!mem_oe_n || (vpp_en && !mem_dq_oe));

  function automatic logic [7:0] look(input logic [15:0] a);
    // The high level overrides whatever logic level line nine carries
    if (id_hv_en) begin
      if (a[15:10] != 6'h00 || a[8:1] != 8'h00) return 8'h00;
      return a[0] ? DEVICE_ID : MAKER_ID;
    end
    return mem[a];
  endfunction : look

  initial begin
    pulses = 0;
    faults = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 16; i++) hits[i] = 0;
  end

  // Any change spoils the data at once, so an early sample reads garbage
  always @(mem_addr or mem_ce_n or mem_oe_n or id_hv_en) begin
    val = ~val;
    val <= #90 look(mem_addr);
  end

  always @(en) begin
    if (en) drv <= #50 1'b1;
    else drv <= #40 1'b0;
  end

  // Released wire shows the inverse of its last level
  always @(val or drv or mem_dq_out or mem_dq_oe) begin
    if (drv) last <= val;
    else if (mem_dq_oe) last <= mem_dq_out;
  end
  assign mem_dq_in = drv ? val : (mem_dq_oe ? mem_dq_out : ~last);

  always @(drv or mem_dq_oe) begin
    if (drv === 1'b1 && mem_dq_oe === 1'b1) faults = faults + 1;
  end

  always @(negedge mem_ce_n) t_low = $realtime;
  always @(posedge mem_ce_n) begin
    if (vpp_en && vcc_prog_en && mem_dq_oe) begin
      pulses = pulses + 1;
      if ($realtime - t_low < PW_MIN_NS || $realtime - t_low > PW_MAX_NS) faults++;
      hits[mem_addr[3:0]]++;
      // Bits only clear; the slow byte takes effect from its third pulse
      if (mem_addr != SLOW_ADDR || hits[mem_addr[3:0]] >= 3) begin
        mem[mem_addr] = mem[mem_addr] & mem_dq_out;
      end
    end
  end
endmodule : oep_mem_model

// ===== tb_oep_ctrl.sv
/*
 Self-checking bench for oep_ctrl with the memory model on its pins.
 Assumes shortened pulse and setup counts and a four-byte programming range.
*/
`timescale 1ns/1ps
module tb_oep_ctrl;
  localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h63; // Arbitrary value
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic rd_req = 1'b0;
  logic rd_id = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic prog_start = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic rd_ready, rd_valid, prog_busy, prog_done, prog_pass, prog_fail;
  logic [7:0] rd_data, mem_dq_in, mem_dq_out;
  logic [15:0] src_addr, fail_addr, mem_addr;
  logic [3:0] fail_retries;
  logic mem_ce_n, mem_oe_n, vpp_en, vcc_prog_en, id_hv_en, mem_dq_oe;
  logic flip = 1'b0;
  logic [7:0] d;
  int pulses, faults, dp;
  int err_count = 0;
  int n_tests = 0;

  oep_ctrl #(.PULSE_CYCLES(10), .SETUP_CYCLES(4), .LAST_ADDR(3)) dut (
    .sys_clk(sys_clk), .reset(reset), .rd_req(rd_req), .rd_id(rd_id), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .prog_start(prog_start),
    .src_addr(src_addr), .src_data(src_data), .prog_busy(prog_busy), .prog_done(prog_done),
    .prog_pass(prog_pass), .prog_fail(prog_fail), .fail_addr(fail_addr),
    .fail_retries(fail_retries), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n), .vpp_en(vpp_en), .vcc_prog_en(vcc_prog_en), .id_hv_en(id_hv_en),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

  oep_mem_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) u_mem (
    .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .vpp_en(vpp_en),
    .vcc_prog_en(vcc_prog_en), .id_hv_en(id_hv_en), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .pulses(pulses), .faults(faults));

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] pat(input logic [15:0] a);
    return 8'hA5 ^ a[7:0] ^ {8{flip}};
  endfunction : pat

  // Byte source answers one cycle after the address
  always @(posedge sys_clk) src_data <= #2 pat(src_addr);

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_flag

  task automatic do_read(input logic id, input logic [15:0] a, output logic [7:0] q);
    int n;
    n = 0;
    while (rd_ready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    rd_req = 1'b1;
    rd_id = id;
    rd_addr = a;
    @(posedge sys_clk);
    #2;
    rd_req = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk_flag(rd_valid, 1'b1, "read answer");
    q = rd_data;
  endtask : do_read

  task automatic prog_run(output int np);
    int n;
    int p0;
    n = 0;
    while (rd_ready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    p0 = pulses;
    prog_start = 1'b1;
    @(posedge sys_clk);
    #2;
    prog_start = 1'b0;
    chk_flag(prog_busy, 1'b1, "busy");
    chk_flag(rd_ready, 1'b0, "reads refused while busy");
    n = 0;
    while (prog_done !== 1'b1 && n < 8000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk_flag(prog_done, 1'b1, "programming done");
    np = pulses - p0;
  endtask : prog_run

  task automatic t_reset;
    chk_flag(mem_ce_n, 1'b1, "ce idle");
    chk_flag(mem_oe_n, 1'b1, "oe idle");
    chk_flag(mem_dq_oe, 1'b0, "dq released");
    chk_flag(vpp_en, 1'b0, "vpp idle");
    chk_flag(id_hv_en, 1'b0, "id level idle");
    $display("test reset done");
  endtask : t_reset

  task automatic t_blank;
    do_read(1'b0, 16'h0001, d);
    chk_val(d, 8'hFF, "blank byte");
    do_read(1'b0, 16'h0200, d);
    chk_val(d, 8'hFF, "line nine without id level");
    $display("test blank read done");
  endtask : t_blank

  task automatic t_ident;
    do_read(1'b1, 16'h0000, d);
    chk_val(d, MAKER, "maker byte");
    do_read(1'b1, 16'h0001, d);
    chk_val(d, DEVICE, "device byte");
    $display("test identification done");
  endtask : t_ident

  task automatic t_prog_ok;
    flip = 1'b0;
    prog_run(dp);
    chk_flag(prog_pass, 1'b1, "pass");
    chk_flag(prog_fail, 1'b0, "no fail");
    chk_val(dp[15:0], 16'h0006, "pulse count");
    chk_flag(vpp_en, 1'b0, "vpp lowered");
    chk_flag(vcc_prog_en, 1'b0, "supply lowered");
    for (int a = 0; a < 4; a++) begin
      do_read(1'b0, a[15:0], d);
      chk_val(d, pat(a[15:0]), "programmed byte");
    end
    do_read(1'b0, 16'h0004, d);
    chk_val(d, 8'hFF, "byte past range");
    $display("test programming pass done");
  endtask : t_prog_ok

  task automatic t_prog_bad;
    flip = 1'b1;
    prog_run(dp);
    chk_flag(prog_fail, 1'b1, "fail");
    chk_flag(prog_pass, 1'b0, "pass cleared");
    chk_val(fail_addr, 16'h0000, "failing address");
    chk_val({12'h000, fail_retries}, 16'h000A, "extra pulses");
    chk_val(dp[15:0], 16'h000E, "pulse count at failure");
    $display("test programming fail done");
  endtask : t_prog_bad

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    #500000;
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #2;
    t_reset();
    reset = 1'b0;
    t_blank();
    t_ident();
    t_prog_ok();
    t_prog_bad();
    chk_val(faults[15:0], 16'h0000, "pulse width and contention");
    finish_test();
  end
endmodule : tb_oep_ctrl
